/* File: pfcc_top.v */
// host-side command controller driving a parallel flash through its pins
//
// Summary of operation
// R1: flash floats data while output enable high
// R2: upper three address bits select sector
// R3: high-voltage id access is programmer only
// R4: two unlocks plus autoselect enter id mode
// R5: id reads: low byte 0 maker, 1 device
// R6: low address 2 returns sector protect flag
// R7: protected sectors refuse program and erase
// R8: all sectors start unprotected
// R9: strobe glitches under 5 ns are ignored
// R10: write only with ce, we low, oe high
// R11: power-up write strobes accept no command
// R12: low supply rejects writes and resets flash
// R13: wrong sequence write returns to array read
// R14: address on later fall, data earlier rise
// R15: array read after power-up and operations
// R16: erase-suspended sectors read status data
// R17: host writes reset after timeout or autoselect
// R18: reset command returns to array read
// R19: reset aborts erase sequence, not erasure
// R20: reset aborts program sequence, not programming
// R21: reset after timeout flag returns to read
// R22: only reset leaves autoselect mode
// R23: unlock and command codes are configurable
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pfcc_defines.vh"
module pfcc_top (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // software register port
  input  wire [3:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_write_in,
  input  wire        reg_read_in,
  output reg  [31:0] reg_rdata_out,
  // flash pins
  output wire        chip_enable_n_out,
  output wire        output_enable_n_out,
  output wire        write_enable_n_out,
  output wire [16:0] flash_addr_out,
  output wire [7:0]  data_bus_out,
  output wire        data_bus_oe_out,
  input  wire [7:0]  data_bus_in
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  localparam [4:0] ST_IDLE = 5'h01;   // waiting for a command
  localparam [4:0] ST_ISSUE = 5'h02;  // start one bus cycle
  localparam [4:0] ST_WAIT = 5'h04;   // wait for bus cycle done
  localparam [4:0] ST_NEXT = 5'h08;   // step in a multi-cycle sequence
  localparam [4:0] ST_FIN = 5'h10;    // finish the command
  reg [4:0]  state;        // one-hot controller state
  reg [16:0] addr_reg;     // target flash address
  reg [7:0]  wdata_reg;    // data for raw write
  reg [2:0]  cmd;          // active command
  reg [1:0]  step;         // position in unlock sequence
  reg        busy;         // a command is running
  reg        autosel;      // flash believed in autoselect mode
  reg        done_flag;    // sticky: last command completed
  reg [7:0]  rdata_reg;    // last read byte
  reg [7:0]  protect_map;  // id-read protect results by sector
  reg        bus_start;    // pulse to cycle engine
  reg        bus_write;    // cycle kind
  reg [16:0] bus_addr;     // cycle address
  reg [7:0]  bus_wdata;    // cycle data
  wire       bus_done;     // cycle finished
  wire [7:0] bus_rdata;    // cycle read data
  reg [31:0] next_rdata;   // register read mux
  // sector number of an address; R2
  function [2:0] pfcc_sector;
    input [16:0] a;
    begin
      pfcc_sector = a[`PFCC_SECT_MSB:`PFCC_SECT_LSB];
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // bus cycle engine
  pfcc_bus_cycle u_cycle (
    .clk_in              (clk_in),
    .reset_n_in          (reset_n_in),
    .start_in            (bus_start),
    .write_in            (bus_write),
    .addr_in             (bus_addr),
    .wdata_in            (bus_wdata),
    .done_out            (bus_done),
    .rdata_out           (bus_rdata),
    .chip_enable_n_out   (chip_enable_n_out),
    .output_enable_n_out (output_enable_n_out),
    .write_enable_n_out  (write_enable_n_out),
    .addr_out            (flash_addr_out),
    .data_bus_out        (data_bus_out),
    .data_bus_oe_out     (data_bus_oe_out),
    .data_bus_in         (data_bus_in)
  );
  ////////////////////////////////////////////////////////////////////////
  // command sequencer
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // strobes held high from reset so no power-up write; R11 R15
      state <= ST_IDLE;
      addr_reg <= 17'h00000;
      wdata_reg <= 8'h00;
      cmd <= 3'h0;
      step <= 2'h0;
      busy <= 1'b0;
      autosel <= 1'b0;
      done_flag <= 1'b0;
      rdata_reg <= 8'h00;
      protect_map <= 8'h00;    // R8
      bus_start <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 17'h00000;
      bus_wdata <= 8'h00;
    end else begin
      bus_start <= 1'b0;
      // software clear of done; completion below wins
      if (reg_write_in && reg_addr_in == `PFCC_REG_STATUS &&
          reg_wdata_in[0]) begin
        done_flag <= 1'b0;
      end
      if (reg_write_in && reg_addr_in == `PFCC_REG_ADDR) begin
        addr_reg <= reg_wdata_in[16:0];
      end
      if (reg_write_in && reg_addr_in == `PFCC_REG_WDATA) begin
        wdata_reg <= reg_wdata_in[7:0];
      end
      case (state)
        ST_IDLE: begin
          // commands while busy are ignored by the idle-only accept
          if (reg_write_in && reg_addr_in == `PFCC_REG_CTRL) begin
            cmd <= reg_wdata_in[2:0];
            step <= 2'h0;
            busy <= 1'b1;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          bus_start <= 1'b1;
          case (cmd)
            `PFCC_CMD_READ, `PFCC_CMD_IDREAD: begin
              // id select bits ride on addr_reg; no high-voltage pin; R3
              bus_write <= 1'b0;
              bus_addr <= addr_reg;
            end
            `PFCC_CMD_WRITE: begin
              // raw write, used for program and erase sequences
              bus_write <= 1'b1;
              bus_addr <= addr_reg;
              bus_wdata <= wdata_reg;
            end
            `PFCC_CMD_RESET: begin
              // address is don't-care; R18 R17 R21 R22
              bus_write <= 1'b1;
              bus_addr <= addr_reg;
              bus_wdata <= `PFCC_RESET_DATA;
            end
            `PFCC_CMD_AUTOSEL: begin
              // two unlock cycles then autoselect code; R4 R23
              bus_write <= 1'b1;
              case (step)
                2'h0: begin
                  bus_addr <= `PFCC_UNLOCK1_ADDR;
                  bus_wdata <= `PFCC_UNLOCK1_DATA;
                end
                2'h1: begin
                  bus_addr <= `PFCC_UNLOCK2_ADDR;
                  bus_wdata <= `PFCC_UNLOCK2_DATA;
                end
                default: begin
                  bus_addr <= `PFCC_UNLOCK1_ADDR;
                  bus_wdata <= `PFCC_AUTOSEL_DATA;
                end
              endcase
            end
            default: begin
              // unknown code: nothing on the pins
              bus_start <= 1'b0;
            end
          endcase
          state <= (cmd >= `PFCC_CMD_READ && cmd <= `PFCC_CMD_IDREAD) ?
                   ST_WAIT : ST_FIN;
        end
        ST_WAIT: begin
          if (bus_done) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (cmd == `PFCC_CMD_AUTOSEL && step != 2'h2) begin
            step <= step + 2'h1;
            state <= ST_ISSUE;
          end else begin
            state <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (cmd == `PFCC_CMD_READ || cmd == `PFCC_CMD_IDREAD) begin
            rdata_reg <= bus_rdata;
          end
          // protect readout: low byte 2 answers 1 or 0; R6
          if (cmd == `PFCC_CMD_IDREAD && autosel &&
              addr_reg[7:0] == `PFCC_ID_PROTECT) begin
            protect_map[pfcc_sector(addr_reg)] <= bus_rdata[0];
          end
          if (cmd == `PFCC_CMD_AUTOSEL) begin
            autosel <= 1'b1;   // R4
          end
          if (cmd == `PFCC_CMD_RESET) begin
            autosel <= 1'b0;   // R22
          end
          busy <= 1'b0;
          done_flag <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register read mux
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr_in)
      `PFCC_REG_CTRL:   next_rdata = {29'h0, cmd};
      `PFCC_REG_ADDR:   next_rdata = {15'h0, addr_reg};
      `PFCC_REG_WDATA:  next_rdata = {24'h0, wdata_reg};
      `PFCC_REG_STATUS: next_rdata = {29'h0, autosel, busy, done_flag};
      `PFCC_REG_RDATA:  next_rdata = {24'h0, rdata_reg};
      `PFCC_REG_SECTOR: next_rdata = {24'h0, protect_map};
      default:          next_rdata = 32'h00000000;
    endcase
  end
  // read data valid the cycle after the strobe only
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

/* File: pfcc_defines.vh */
// constants for the parallel flash command controller
`ifndef PFCC_DEFINES_VH
`define PFCC_DEFINES_VH
// register offsets of the controller's own port (word index)
`define PFCC_REG_CTRL      4'h0
`define PFCC_REG_ADDR      4'h1
`define PFCC_REG_WDATA     4'h2
`define PFCC_REG_STATUS    4'h3
`define PFCC_REG_RDATA     4'h4
`define PFCC_REG_SECTOR    4'h5
// command codes written to ctrl bits [2:0]
`define PFCC_CMD_READ      3'h1
`define PFCC_CMD_WRITE     3'h2
`define PFCC_CMD_RESET     3'h3
`define PFCC_CMD_AUTOSEL   3'h4
`define PFCC_CMD_IDREAD    3'h5
// unlock cycle addresses and data, command codes (configurable)
`define PFCC_UNLOCK1_ADDR  17'h00555
`define PFCC_UNLOCK1_DATA  8'hAA
`define PFCC_UNLOCK2_ADDR  17'h002AA
`define PFCC_UNLOCK2_DATA  8'h55
`define PFCC_AUTOSEL_DATA  8'h90
`define PFCC_RESET_DATA    8'hF0
// autoselect low address values
`define PFCC_ID_MANUF      8'h00
`define PFCC_ID_DEVICE     8'h01
`define PFCC_ID_PROTECT    8'h02
// sector field position
`define PFCC_SECT_MSB      16
`define PFCC_SECT_LSB      14
// bus cycle timing
`define PFCC_CLK_PS        10000
`define PFCC_T_STROBE_PS   50000
`define PFCC_STROBE_CYC    ((`PFCC_T_STROBE_PS+`PFCC_CLK_PS-1)/`PFCC_CLK_PS)
`define PFCC_T_SETUP_PS    10000
`define PFCC_SETUP_CYC     ((`PFCC_T_SETUP_PS+`PFCC_CLK_PS-1)/`PFCC_CLK_PS)
`endif

/* File: pfcc_bus_cycle.v */
// one strobe-level bus cycle engine toward the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "pfcc_defines.vh"
module pfcc_bus_cycle (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // request side
  input  wire        start_in,
  input  wire        write_in,
  input  wire [16:0] addr_in,
  input  wire [7:0]  wdata_in,
  output reg         done_out,
  output reg  [7:0]  rdata_out,
  // flash pins
  output reg         chip_enable_n_out,
  output reg         output_enable_n_out,
  output reg         write_enable_n_out,
  output reg  [16:0] addr_out,
  output reg  [7:0]  data_bus_out,
  output reg         data_bus_oe_out,
  input  wire [7:0]  data_bus_in
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SET  = 4'h2;
  localparam [3:0] ST_STB  = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;
  localparam integer SET_I = `PFCC_SETUP_CYC;   // setup length, cycles
  localparam integer STB_I = `PFCC_STROBE_CYC;  // strobe length, cycles
  // counts are small; cut to the counter width on purpose
  localparam [3:0] SET_N   = SET_I[3:0];
  localparam [3:0] STB_N   = STB_I[3:0];
  reg [3:0] state;         // one-hot phase
  reg [3:0] cnt;           // phase cycle count
  reg       is_wr;         // current cycle is a write
  ////////////////////////////////////////////////////////////////////////
  // sequencer: setup, strobe, hold; strobes last far beyond 5 ns
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      is_wr <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 8'h00;
      chip_enable_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      addr_out <= 17'h00000;
      data_bus_out <= 8'h00;
      data_bus_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            // address stable before any strobe falls; R14
            addr_out <= addr_in;
            data_bus_out <= wdata_in;
            is_wr <= write_in;
            // never drive data while flash may output; R1
            output_enable_n_out <= 1'b1;
            cnt <= 4'h0;
            state <= ST_SET;
          end
        end
        ST_SET: begin
          // drive data only for writes, with oe high
          data_bus_oe_out <= is_wr;
          if (cnt + 4'h1 >= SET_N) begin
            cnt <= 4'h0;
            chip_enable_n_out <= 1'b0;
            // write: ce and we low, oe high; read: oe low, we high; R10 R9
            write_enable_n_out <= ~is_wr;
            output_enable_n_out <= is_wr;
            state <= ST_STB;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        ST_STB: begin
          if (cnt + 4'h1 >= STB_N) begin
            cnt <= 4'h0;
            // we rises first so data latch happens with data held; R14
            write_enable_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            if (!is_wr) begin
              rdata_out <= data_bus_in;
            end
            state <= ST_HOLD;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        ST_HOLD: begin
          chip_enable_n_out <= 1'b1;
          data_bus_oe_out <= 1'b0;
          done_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: pfcc_assertions.sv */
// pin-level checks for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module pfcc_chk (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  // flash pins
  input wire logic        chip_enable_n_out,
  input wire logic        output_enable_n_out,
  input wire logic        write_enable_n_out,
  input wire logic [16:0] flash_addr_out,
  input wire logic [7:0]  data_bus_out,
  input wire logic        data_bus_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////
  // strobes stay low five cycles, well clear of the glitch filter
  sequence s_we_pulse;
    !write_enable_n_out [*5] ##1 write_enable_n_out;
  endsequence
  sequence s_oe_pulse;
    !output_enable_n_out [*5] ##1 output_enable_n_out;
  endsequence
  a_host_no_clash:
    assert property (data_bus_oe_out |-> output_enable_n_out)
    else $error("host drives data while flash outputs are on");
  a_write_qualified:
    assert property (!write_enable_n_out |->
      !chip_enable_n_out && output_enable_n_out)
    else $error("write strobe without chip enable or with oe low");
  a_we_pulse_len:
    assert property ($fell(write_enable_n_out) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_oe_pulse_len:
    assert property ($fell(output_enable_n_out) |-> s_oe_pulse)
    else $error("output enable width wrong");
  a_data_held:
    assert property (!write_enable_n_out |->
      data_bus_oe_out && $stable(data_bus_out))
    else $error("write data moved during strobe");
  a_data_at_rise:
    assert property ($rose(write_enable_n_out) |-> !chip_enable_n_out
      && data_bus_oe_out && $stable(data_bus_out))
    else $error("write data not held at strobe rise");
  a_addr_setup:
    assert property (!chip_enable_n_out |-> $stable(flash_addr_out))
    else $error("address moved while chip enabled");
  a_ce_after_we:
    assert property ($rose(write_enable_n_out) |=> $rose(chip_enable_n_out))
    else $error("chip enable not released after write strobe");
  a_reset_idle:
    assert property ($rose(reset_n_in) |-> chip_enable_n_out
      && write_enable_n_out && output_enable_n_out)
    else $error("strobes active on reset release");
endmodule
bind pfcc_top pfcc_chk u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in),
  .chip_enable_n_out(chip_enable_n_out),
  .output_enable_n_out(output_enable_n_out),
  .write_enable_n_out(write_enable_n_out),
  .flash_addr_out(flash_addr_out), .data_bus_out(data_bus_out),
  .data_bus_oe_out(data_bus_oe_out)
);
`default_nettype wire

/* File: pfcc_flash_model.sv */
// behavioural flash device as seen at its pins
`timescale 1ns/1ps
`default_nettype none
`include "pfcc_defines.vh"
module pfcc_flash_model #(
  parameter [7:0] MAKER_ID = 8'hA5, // arbitrary value
  parameter [7:0] PART_ID  = 8'h3C, // arbitrary value
  parameter [7:0] PROT_MAP = 8'h00
) (
  // strobes, address and bus level
  input  wire logic        chip_enable_n_in,
  input  wire logic        output_enable_n_in,
  input  wire logic        write_enable_n_in,
  input  wire logic [16:0] addr_in,
  input  wire logic [7:0]  data_in,
  // read data and drive flag
  output var  logic [7:0]  data_out,
  output wire logic        drive_out
);
  logic [16:0] lat_addr;        // taken on the later falling strobe
  logic        armed = 1'b0;    // a real write strobe has fallen
  logic [1:0]  mode = 2'h0;     // 0 array, 1-2 unlocks, 3 id mode
  logic [7:0]  val;             // value the flash would show: array data, or an id code in id mode
  wire         wr_n = chip_enable_n_in | write_enable_n_in
                      | ~output_enable_n_in;
  wire  [24:0] want = (mode == 2'h0) ?
    {`PFCC_UNLOCK1_ADDR, `PFCC_UNLOCK1_DATA} : (mode == 2'h1) ?
    {`PFCC_UNLOCK2_ADDR, `PFCC_UNLOCK2_DATA} :
    {`PFCC_UNLOCK1_ADDR, `PFCC_AUTOSEL_DATA};
  ////////////////////////////////////////////////////////////////////////
  always @(negedge wr_n) begin
    lat_addr = addr_in;
    armed = 1'b1;
  end
  // command decode on the earlier rising strobe; a rise with no fall
  // before it (pins leaving unknown at power-up) carries no command
  always @(posedge wr_n) begin
    if (armed) begin
      armed = 1'b0;
      if (data_in == `PFCC_RESET_DATA)
        mode = 2'h0;
      else if (mode != 2'h3)
        mode = ({lat_addr, data_in} == want) ? mode + 2'h1 : 2'h0;
    end
  end
  // id codes only in id mode, at any high address
  always @* begin
    if (mode != 2'h3)
      val = addr_in[7:0] ^ addr_in[16:9];
    else if (addr_in[7:0] == `PFCC_ID_MANUF)
      val = MAKER_ID;
    else if (addr_in[7:0] == `PFCC_ID_DEVICE)
      val = PART_ID;
    else
      val = {7'h00, PROT_MAP[addr_in[16:14]]};
  end
  // floating bus shows the inverse so a stale value never passes
  assign drive_out = ~chip_enable_n_in & ~output_enable_n_in;
  always @* data_out = drive_out ? val : ~val;
endmodule
`default_nettype wire

/* File: pfcc_tb_top.sv */
// self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
`include "pfcc_defines.vh"
module pfcc_tb_top;
  localparam [7:0] PROT  = 8'h24; // sectors two and five locked
  localparam [7:0] MAKER = 8'hA5; // arbitrary value
  localparam [7:0] PART  = 8'h3C; // arbitrary value
  logic        clk_in       = 1'h0;
  logic        reset_n_in   = 1'h0;
  logic [3:0]  reg_addr_in  = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_write_in = 1'h0;
  logic        reg_read_in  = 1'h0;
  logic [31:0] rd;
  int          fail_count   = 0;
  int          num_checks   = 0;
  wire  [31:0] reg_rdata_out;
  wire         ce_n, oe_n, we_n, bus_oe, f_drive;
  wire  [16:0] f_addr;
  wire  [7:0]  bus_out, f_data, bus_lvl;
  // wire level from both parties
  assign bus_lvl = f_drive ? f_data : bus_oe ? bus_out : ~bus_out;
  pfcc_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .chip_enable_n_out(ce_n),
    .output_enable_n_out(oe_n), .write_enable_n_out(we_n),
    .flash_addr_out(f_addr), .data_bus_out(bus_out),
    .data_bus_oe_out(bus_oe), .data_bus_in(bus_lvl));
  pfcc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .PROT_MAP(PROT))
    u_flash (.chip_enable_n_in(ce_n), .output_enable_n_in(oe_n),
    .write_enable_n_in(we_n), .addr_in(f_addr), .data_in(bus_lvl),
    .data_out(f_data), .drive_out(f_drive));
  initial forever #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_write_in <= 1'h1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_write_in <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_in);
    reg_read_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_read_in <= 1'h0;
    #1 rd = reg_rdata_out;
  endtask
  // bounded wait on done, then clear it
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      rdr(`PFCC_REG_STATUS);
      if (rd[0] === 1'h1) break;
    end
    chk(rd[0], 32'h1, "command done");
    wr(`PFCC_REG_STATUS, 32'h1);
  endtask
  // one flash command: address, data, then the order
  task automatic cmd(input logic [2:0] c, input logic [16:0] a,
                     input logic [7:0] d);
    wr(`PFCC_REG_ADDR, {15'h0, a});
    wr(`PFCC_REG_WDATA, {24'h0, d});
    wr(`PFCC_REG_CTRL, {29'h0, c});
    wait_done();
  endtask
  function automatic logic [31:0] arr(input logic [16:0] a);
    return {24'h0, a[7:0] ^ a[16:9]};
  endfunction
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_in);
    chk({ce_n, oe_n, we_n, bus_oe}, 32'hE, "idle pins");
    reset_n_in <= 1'h1;
    rdr(`PFCC_REG_STATUS);
    chk(rd, 32'h0, "status after reset");
    rdr(4'hF);
    chk(rd, 32'h0, "unmapped read");
    cmd(`PFCC_CMD_READ, 17'h1C0A3, 8'h00);
    rdr(`PFCC_REG_RDATA);
    chk(rd, arr(17'h1C0A3), "array read");
    $display("test reset and array done");
    // a wrong second unlock must leave the flash in array read
    cmd(`PFCC_CMD_WRITE, `PFCC_UNLOCK1_ADDR, `PFCC_UNLOCK1_DATA);
    cmd(`PFCC_CMD_WRITE, `PFCC_UNLOCK2_ADDR, 8'h00);
    cmd(`PFCC_CMD_WRITE, `PFCC_UNLOCK1_ADDR, `PFCC_AUTOSEL_DATA);
    cmd(`PFCC_CMD_READ, 17'h00100, 8'h00);
    rdr(`PFCC_REG_RDATA);
    chk(rd, arr(17'h00100), "aborted sequence");
    $display("test abort done");
    cmd(`PFCC_CMD_AUTOSEL, 17'h00000, 8'h00);
    rdr(`PFCC_REG_STATUS);
    chk(rd[2], 32'h1, "id mode flag");
    cmd(`PFCC_CMD_IDREAD, 17'h1F300, 8'h00);
    rdr(`PFCC_REG_RDATA);
    chk(rd, {24'h0, MAKER}, "maker code");
    cmd(`PFCC_CMD_IDREAD, 17'h0AB01, 8'h00);
    rdr(`PFCC_REG_RDATA);
    chk(rd, {24'h0, PART}, "part code");
    for (int s = 0; s < 8; s++) begin
      cmd(`PFCC_CMD_IDREAD, {s[2:0], 14'h0002}, 8'h00);
      rdr(`PFCC_REG_RDATA);
      chk(rd, {31'h0, PROT[s]}, "protect bit");
    end
    rdr(`PFCC_REG_SECTOR);
    chk(rd, {24'h0, PROT}, "protect map");
    $display("test id mode done");
    cmd(`PFCC_CMD_RESET, 17'h15A5A, 8'h00);
    rdr(`PFCC_REG_STATUS);
    chk(rd[2], 32'h0, "id mode left");
    cmd(`PFCC_CMD_READ, 17'h00001, 8'h00);
    rdr(`PFCC_REG_RDATA);
    chk(rd, arr(17'h00001), "array after reset");
    $display("test reset command done");
    // an order while busy is dropped: id mode must not be entered
    wr(`PFCC_REG_ADDR, 32'h00000003);
    wr(`PFCC_REG_CTRL, {29'h0, `PFCC_CMD_READ});
    wr(`PFCC_REG_CTRL, {29'h0, `PFCC_CMD_AUTOSEL});
    wait_done();
    rdr(`PFCC_REG_CTRL);
    chk(rd, {29'h0, `PFCC_CMD_READ}, "order while busy");
    rdr(`PFCC_REG_RDATA);
    chk(rd, arr(17'h00003), "read beside dropped order");
    // an unknown code completes with no bus cycle on the pins
    cmd(3'h7, 17'h00000, `PFCC_RESET_DATA);
    rdr(`PFCC_REG_CTRL);
    chk(rd, 32'h7, "unknown code kept");
    cmd(`PFCC_CMD_READ, 17'h10000, 8'h00);
    rdr(`PFCC_REG_RDATA);
    chk(rd, arr(17'h10000), "array after unknown code");
    $display("test refused orders done");
    finish_test();
  end
  // about twenty commands of a few dozen cycles each fit easily
  initial begin
    #200000;
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
